// >>> dpect_defines.svh
`ifndef DPECT_DEFINES_SVH
`define DPECT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DPECT_IDX_A_RISE 8'h40
`define DPECT_IDX_A_FALL 8'h41
`define DPECT_IDX_B_RISE 8'h42
`define DPECT_IDX_B_FALL 8'h43
`define DPECT_IDX_CONFIG 8'h44
`define DPECT_IDX_FLAGS 8'h45
`define DPECT_IDX_IRQ_STATUS 8'h46
`define DPECT_IDX_IRQ_MASK 8'h47
`define DPECT_IDX_GLOBAL_EN 8'h48

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define DPECT_HOLD_BIT 7
`define DPECT_PRESCALE_LSB 4
`define DPECT_PRESCALE_MAX 3'h4
`define DPECT_CONFIG_RESET 8'h00
`define DPECT_FLAGS_RESET 4'h0
`define DPECT_CAPTURE_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DPECT_TICK_NS 1000
`define DPECT_CLK_NS 40
`define DPECT_TICK_CYCLES (`DPECT_TICK_NS / `DPECT_CLK_NS)

`endif

// >>> dpect_pkg.sv
package dpect_pkg;

    // ------------------------------------------------------------------------
    // Capture configuration layout
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic hold;
        logic [2:0] prescale;
        logic [3:0] intEnable;
    } dpect_cfg_type;

    // ------------------------------------------------------------------------
    // One bit per capture event, in status bit order
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic bFall;
        logic bRise;
        logic aFall;
        logic aRise;
    } dpect_evt_type;

endpackage : dpect_pkg

// >>> dual_pin_edge_capture_timer.sv
`timescale 1ns/1ns
`include "dpect_defines.svh"

module dual_pin_edge_capture_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [1:0] port0Pins,
    output logic captureIrq,
    output logic captureReqA,
    output logic captureReqB
);

    // ------------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------------
    localparam logic [4:0] TICK_LAST = 5'(`DPECT_TICK_CYCLES - 1);
    localparam logic [11:0] TIMER_ONE = 12'h001;

    // ------------------------------------------------------------------------
    // Microsecond timer
    // ------------------------------------------------------------------------
    logic [4:0] tickCount_reg;
    logic [4:0] tickCount_next;
    logic [11:0] timer_reg;
    logic [11:0] timer_next;
    wire tickLast = (tickCount_reg == TICK_LAST);

    assign tickCount_next = tickLast ? 5'h00 : tickCount_reg + 5'h01;
    assign timer_next = tickLast ? timer_reg + TIMER_ONE : timer_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            tickCount_reg <= 5'h00;
            timer_reg <= 12'h000;
        end else begin
            tickCount_reg <= tickCount_next;
            timer_reg <= timer_next;
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchroniser and edge detection
    // ------------------------------------------------------------------------
    logic [1:0] pinMeta_reg;
    logic [1:0] pinSync_reg;
    logic [1:0] pinLast_reg;
    dpect_pkg::dpect_evt_type evt;

    // Bit 0 of the pin group feeds channel A, bit 1 feeds channel B.
    always_ff @(posedge clk) begin
        if (reset) begin
            pinMeta_reg <= 2'h0;
            pinSync_reg <= 2'h0;
            pinLast_reg <= 2'h0;
        end else begin
            pinMeta_reg <= port0Pins;
            pinSync_reg <= pinMeta_reg;
            pinLast_reg <= pinSync_reg;
        end
    end

    assign evt.aRise = pinSync_reg[0] & ~pinLast_reg[0];
    assign evt.aFall = ~pinSync_reg[0] & pinLast_reg[0];
    assign evt.bRise = pinSync_reg[1] & ~pinLast_reg[1];
    assign evt.bFall = ~pinSync_reg[1] & pinLast_reg[1];

    // ------------------------------------------------------------------------
    // Prescaled timer slice
    // ------------------------------------------------------------------------
    dpect_pkg::dpect_cfg_type cfg_reg;
    dpect_pkg::dpect_cfg_type cfg_next;
    wire [2:0] shiftAmt = (cfg_reg.prescale > `DPECT_PRESCALE_MAX) ?
        `DPECT_PRESCALE_MAX : cfg_reg.prescale;
    wire [11:0] timerShifted = timer_reg >> shiftAmt;
    // Each step up to code 4 drops one more low bit, so the LSB weight doubles.
    wire [7:0] timerSlice = timerShifted[7:0];

    // ------------------------------------------------------------------------
    // Avalon slave decode
    // ------------------------------------------------------------------------
    logic waitrequest_reg;
    logic [31:0] readdata_reg;
    wire busReq = read | write;
    // Side effects happen at the edge where a new request is first seen.
    wire accept = busReq & waitrequest_reg;
    wire [7:0] regIdx = address[9:2];
    wire hitConfig = (regIdx == `DPECT_IDX_CONFIG);
    wire hitFlags = (regIdx == `DPECT_IDX_FLAGS);
    wire hitIrqStatus = (regIdx == `DPECT_IDX_IRQ_STATUS);
    wire hitIrqMask = (regIdx == `DPECT_IDX_IRQ_MASK);
    wire hitGlobalEn = (regIdx == `DPECT_IDX_GLOBAL_EN);
    wire [3:0] hitCapture;
    assign hitCapture[0] = (regIdx == `DPECT_IDX_A_RISE);
    assign hitCapture[1] = (regIdx == `DPECT_IDX_A_FALL);
    assign hitCapture[2] = (regIdx == `DPECT_IDX_B_RISE);
    assign hitCapture[3] = (regIdx == `DPECT_IDX_B_FALL);
    wire doWrite = accept & write & byteenable[0];
    wire [3:0] readCapture = {4{accept & read}} & hitCapture;
    wire [7:0] wrByte = writedata[7:0];

    // ------------------------------------------------------------------------
    // Configuration and interrupt control
    // ------------------------------------------------------------------------
    logic [1:0] irqStatus_reg;
    logic [1:0] irqStatus_next;
    logic [1:0] irqMask_reg;
    logic globalEn_reg;
    logic captureIrq_reg;
    logic captureReqA_reg;
    logic captureReqB_reg;
    wire [1:0] irqSet;
    wire [1:0] irqClear = (doWrite & hitIrqStatus) ? wrByte[1:0] : 2'h0;

    assign cfg_next = (doWrite & hitConfig) ? wrByte : cfg_reg;
    // Both events of a pin share one request line.
    assign irqSet[0] = |(evt[1:0] & cfg_reg.intEnable[1:0]);
    assign irqSet[1] = |(evt[3:2] & cfg_reg.intEnable[3:2]);
    // A new event wins over a clear arriving in the same cycle.
    assign irqStatus_next = irqSet | (irqStatus_reg & ~irqClear);
    wire irqPending = |(irqStatus_reg & irqMask_reg);

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_reg <= `DPECT_CONFIG_RESET;
            irqStatus_reg <= 2'h0;
            irqMask_reg <= 2'h0;
            globalEn_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            irqStatus_reg <= irqStatus_next;
            if (doWrite & hitIrqMask) begin
                irqMask_reg <= wrByte[1:0];
            end
            if (doWrite & hitGlobalEn) begin
                globalEn_reg <= wrByte[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            captureIrq_reg <= 1'b0;
            captureReqA_reg <= 1'b0;
            captureReqB_reg <= 1'b0;
        end else begin
            captureIrq_reg <= irqPending & globalEn_reg;
            captureReqA_reg <= irqStatus_reg[0] & globalEn_reg;
            captureReqB_reg <= irqStatus_reg[1] & globalEn_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------------------
    logic [7:0] capData_reg [4];
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [3:0] capLoad;

    // A read in the same cycle releases the hold so the new edge is kept.
    assign capLoad = evt & ({4{~cfg_reg.hold}} | ~flags_reg | readCapture);
    // A new edge wins over the clear caused by a read in the same cycle.
    assign flags_next = evt | (flags_reg & ~readCapture);

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= `DPECT_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    for (genvar ch = 0; ch < 4; ch++) begin : gCapture
        // Writes never reach this register; only edges load it.
        always_ff @(posedge clk) begin
            if (reset) begin
                capData_reg[ch] <= `DPECT_CAPTURE_RESET;
            end else if (capLoad[ch]) begin
                capData_reg[ch] <= timerSlice;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read data and wait request
    // ------------------------------------------------------------------------
    wire [7:0] readMux =
        hitCapture[0] ? capData_reg[0] :
        hitCapture[1] ? capData_reg[1] :
        hitCapture[2] ? capData_reg[2] :
        hitCapture[3] ? capData_reg[3] :
        hitConfig ? cfg_reg :
        hitFlags ? {4'h0, flags_reg} :
        hitIrqStatus ? {6'h00, irqStatus_reg} :
        hitIrqMask ? {6'h00, irqMask_reg} :
        hitGlobalEn ? {7'h00, globalEn_reg} :
        8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            waitrequest_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            waitrequest_reg <= ~accept;
            readdata_reg <= (accept & read) ? {24'h00_0000, readMux} :
                32'h0000_0000;
        end
    end

    assign readdata = readdata_reg;
    assign waitrequest = waitrequest_reg;
    assign captureIrq = captureIrq_reg;
    assign captureReqA = captureReqA_reg;
    assign captureReqB = captureReqB_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    pin_edge_sync_a: assert property (
        @(posedge clk) disable iff (reset)
        evt.aRise |-> $past(port0Pins[0], 2) && !$past(port0Pins[0], 3)
    ) else $error("Channel A rise not two syncs after pin 0 rose.");

    pin_b_sync_a: assert property (
        @(posedge clk) disable iff (reset)
        evt.bFall |-> !$past(port0Pins[1], 2) && $past(port0Pins[1], 3)
    ) else $error("Channel B fall not two syncs after pin 1 fell.");

    capture_value_a: assert property (
        @(posedge clk) disable iff (reset)
        evt.aFall && !cfg_reg.hold |=> capData_reg[1] == $past(timerSlice)
    ) else $error("Falling edge on A did not capture the timer slice.");

    capture_readonly_a: assert property (
        @(posedge clk) disable iff (reset)
        doWrite && hitCapture[2] && !evt.bRise |=>
            capData_reg[2] == $past(capData_reg[2])
    ) else $error("Write changed a capture data register.");

    prescale_slice_a: assert property (
        @(posedge clk) disable iff (reset)
        cfg_reg.prescale == 3'h3 |-> timerSlice == timer_reg[10:3]
    ) else $error("Prescale code 3 did not select timer bits 10:3.");

    prescale_reserved_a: assert property (
        @(posedge clk) disable iff (reset)
        cfg_reg.prescale > 3'h4 |-> timerSlice == timer_reg[11:4]
    ) else $error("Reserved prescale code did not behave as code 4.");

    slice_weight_a: assert property (
        @(posedge clk) disable iff (reset)
        cfg_reg.prescale == 3'h0 && tickLast && timer_reg[7:0] != 8'hff &&
            !(doWrite && hitConfig) |=>
            timerSlice == $past(timerSlice) + 8'h01
    ) else $error("Slice at code 0 did not step by one per microsecond.");

    timer_tick_a: assert property (
        @(posedge clk) disable iff (reset)
        !tickLast |=> $stable(timer_reg)
    ) else $error("Timer advanced between microsecond ticks.");

    tick_period_a: assert property (
        @(posedge clk) disable iff (reset)
        tickLast |=> !tickLast [*8] ##16 !tickLast ##1 tickLast
    ) else $error("Microsecond tick period is not 25 cycles.");

    flag_set_a: assert property (
        @(posedge clk) disable iff (reset)
        evt.bFall |=> flags_reg[3]
    ) else $error("B falling edge did not set its flag.");

    read_clear_a: assert property (
        @(posedge clk) disable iff (reset)
        readCapture[0] && evt == 4'h0 |=>
            !flags_reg[0] && flags_reg[3:1] == $past(flags_reg[3:1])
    ) else $error("Read of A rise data cleared the wrong flags.");

    hold_keep_a: assert property (
        @(posedge clk) disable iff (reset)
        cfg_reg.hold && flags_reg[0] && evt.aRise && !readCapture[0] |=>
            $stable(capData_reg[0])
    ) else $error("Held capture was overwritten before a read.");

    hold_global_a: assert property (
        @(posedge clk) disable iff (reset)
        cfg_reg.hold && flags_reg[3] && evt.bFall && !readCapture[3] |=>
            $stable(capData_reg[3])
    ) else $error("Hold did not apply to the B fall register.");

    overwrite_a: assert property (
        @(posedge clk) disable iff (reset)
        !cfg_reg.hold && flags_reg[2] && evt.bRise |=>
            capData_reg[2] == $past(timerSlice)
    ) else $error("Without hold a later edge did not overwrite.");

    irq_merge_a: assert property (
        @(posedge clk) disable iff (reset)
        evt.aFall && cfg_reg.intEnable[1] |=> irqStatus_reg[0]
    ) else $error("Enabled A event did not raise the A request.");

    irq_enable_a: assert property (
        @(posedge clk) disable iff (reset)
        !irqStatus_reg[1] && cfg_reg.intEnable[3:2] == 2'h0 &&
            !(doWrite && hitConfig) |=> !irqStatus_reg[1]
    ) else $error("Disabled B events raised the B request.");

    irq_gate_a: assert property (
        @(posedge clk) disable iff (reset)
        captureIrq_reg |-> $past(globalEn_reg) && $past(irqPending)
    ) else $error("Interrupt forwarded without global enable.");

    reset_zero_a: assert property (
        @(posedge clk)
        $past(reset) |-> cfg_reg == 8'h00 && flags_reg == 4'h0 &&
            capData_reg[0] == 8'h00 && capData_reg[3] == 8'h00
    ) else $error("Registers not zero after reset.");

    bus_answer_a: assert property (
        @(posedge clk) disable iff (reset)
        accept |=> !waitrequest_reg ##1 waitrequest_reg
    ) else $error("Bus answer did not come one cycle after the request.");

endmodule : dual_pin_edge_capture_timer

// >>> dpect_pin_source.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// External signal source for the two capture pins
// ----------------------------------------------------------------------------
// The source is clocked by the capture clock. It moves its pins on the
// falling edge, so the capture logic cannot rely on edges that line up with
// its own sampling edge.
module dpect_pin_source (
    input wire logic clk,
    input wire logic [1:0] pinTarget,
    output logic [1:0] port0Pins
);
    always @(negedge clk) begin
        port0Pins <= pinTarget;
    end
endmodule : dpect_pin_source

// >>> dual_pin_edge_capture_timer_tb_top.sv
`timescale 1ns/1ns
`include "dpect_defines.svh"
`define CHECK(what, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
end

module dual_pin_edge_capture_timer_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] port0Pins;
    logic [1:0] pinTarget = 2'b00;
    logic captureIrq;
    logic captureReqA;
    logic captureReqB;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [11:0] stamp [4];
    logic [31:0] rd;
    dpect_pkg::dpect_cfg_type cfg;

    always #20 clk = ~clk;

    // Cycles since reset release; the capture timer advances every 25.
    always @(posedge clk) cyc <= reset ? 0 : cyc + 1;

    dual_pin_edge_capture_timer dut_u (
        .clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .port0Pins(port0Pins), .captureIrq(captureIrq),
        .captureReqA(captureReqA), .captureReqB(captureReqB)
    );

    dpect_pin_source source_u (
        .clk(clk), .pinTarget(pinTarget), .port0Pins(port0Pins)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task conclude;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wdata,
             output logic [31:0] data);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, wdata};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        data = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task wr(input logic [7:0] idx, input logic [7:0] wdata);
        bus(1'b1, idx, wdata, rd);
    endtask : wr

    task rdCheck(input logic [7:0] idx, input logic [7:0] exp,
                 input string what);
        bus(1'b0, idx, 8'h00, rd);
        `CHECK(what, {24'h000000, exp}, rd)
    endtask : rdCheck

    // Moves the pins in the middle of a microsecond so the stamp is exact.
    task setPins(input logic [1:0] level, input int us,
                 output logic [11:0] t);
        int target;
        target = (cyc / 25 + us) * 25 + 10;
        while (cyc < target) @(posedge clk);
        t = 12'(cyc / 25);
        pinTarget <= level;
    endtask : setPins

    function automatic logic [7:0] slice(input logic [11:0] t,
                                         input logic [2:0] p);
        return 8'(t >> ((p > 3'h4) ? 3'h4 : p));
    endfunction : slice

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        #(60000 * 40);
        num_errors++;
        conclude();
    end

    initial begin
        void'($urandom(26559));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 9; k++) begin
            rdCheck(8'h40 + 8'(k), 8'h00, "reset");
        end
        for (int k = 0; k < 6; k++) begin
            if (k != 4) begin
                wr(8'h40 + 8'(k), 8'hff);
                rdCheck(8'h40 + 8'(k), 8'h00, "read only");
            end
        end
        rdCheck(8'h50, 8'h00, "unmapped");
        wr(`DPECT_IDX_CONFIG, 8'ha5);
        rdCheck(`DPECT_IDX_CONFIG, 8'ha5, "config");
        for (int p = 0; p < 8; p++) begin
            cfg = '{hold: 1'b0, prescale: 3'(p), intEnable: 4'($urandom)};
            wr(`DPECT_IDX_CONFIG, cfg);
            setPins(2'b01, $urandom_range(1, 60), stamp[0]);
            setPins(2'b11, $urandom_range(1, 60), stamp[2]);
            setPins(2'b10, $urandom_range(1, 60), stamp[1]);
            setPins(2'b00, $urandom_range(1, 60), stamp[3]);
            repeat (8) @(posedge clk);
            rdCheck(`DPECT_IDX_FLAGS, 8'h0f, "all flags");
            for (int k = 0; k < 4; k++) begin
                rdCheck(8'h40 + 8'(k), slice(stamp[k], 3'(p)),
                        "stamp");
                rdCheck(`DPECT_IDX_FLAGS, 8'h0f & 8'(8'h0f << (k + 1)),
                        "flags");
            end
        end
        cfg = '{hold: 1'b1, prescale: 3'h0, intEnable: 4'h0};
        for (int h = 1; h >= 0; h--) begin
            cfg.hold = h[0];
            wr(`DPECT_IDX_CONFIG, cfg);
            setPins(2'b11, 3, stamp[0]);
            setPins(2'b00, 3, stamp[1]);
            setPins(2'b11, 3, stamp[2]);
            setPins(2'b00, 3, stamp[3]);
            repeat (8) @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                rdCheck(8'h40 + 8'(k), slice(stamp[k % 2 + (h ? 0 : 2)],
                        3'h0), "hold");
            end
        end
        wr(`DPECT_IDX_IRQ_MASK, 8'h03);
        wr(`DPECT_IDX_GLOBAL_EN, 8'h00);
        wr(`DPECT_IDX_IRQ_STATUS, 8'h03);
        cfg = '{hold: 1'b0, prescale: 3'h0, intEnable: 4'b0010};
        wr(`DPECT_IDX_CONFIG, cfg);
        setPins(2'b01, 2, stamp[0]);
        repeat (8) @(posedge clk);
        rdCheck(`DPECT_IDX_IRQ_STATUS, 8'h00, "disabled event");
        setPins(2'b00, 2, stamp[1]);
        repeat (8) @(posedge clk);
        rdCheck(`DPECT_IDX_IRQ_STATUS, 8'h01, "enabled event");
        `CHECK("reqA gated", 1'b0, captureReqA)
        `CHECK("irq gated", 1'b0, captureIrq)
        wr(`DPECT_IDX_GLOBAL_EN, 8'h01);
        repeat (2) @(posedge clk);
        `CHECK("reqA", 1'b1, captureReqA)
        `CHECK("irq", 1'b1, captureIrq)
        `CHECK("reqB idle", 1'b0, captureReqB)
        cfg.intEnable = 4'b0100;
        wr(`DPECT_IDX_CONFIG, cfg);
        setPins(2'b10, 2, stamp[2]);
        repeat (8) @(posedge clk);
        `CHECK("reqB", 1'b1, captureReqB)
        wr(`DPECT_IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        `CHECK("irq masked", 1'b0, captureIrq)
        wr(`DPECT_IDX_IRQ_STATUS, 8'h03);
        repeat (2) @(posedge clk);
        `CHECK("reqA cleared", 1'b0, captureReqA)
        rdCheck(`DPECT_IDX_IRQ_STATUS, 8'h00, "status cleared");
        conclude();
    end
endmodule : dual_pin_edge_capture_timer_tb_top
